//--- hdl/ebr_ram.sv
// Embedded true dual-port block RAM with byte masking and output registers
`include "ebr_consts.svh"

// Behaviour
// - Stores 4096 data bits, 4608 with parity
// - Nine shapes, 4K x 1 to 128 x 36
// - Two independent ports, any read/write mix
// - Masked bytes keep their stored value
// - No mask means write enable alone decides
// - Same-port read during write returns new data
// - Other-port read during write returns old data
// - Clock enable low freezes the whole block except the output clears
// - Input registers never cleared; clears hit output registers only
// - Output clear acts at once, no clock
// - Output registers cleared by power-up, clear, chip clear; flow-through data is not
// - Inputs registered; output register optional
// - Intended for clock rates up to 250 MHz
module ebr_ram (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic                  out_aclr,
    input  wire logic                  chip_wide_clear_n,
    input  wire ebr_pkg::ebr_shape_t   a_shape,
    input  wire ebr_pkg::ebr_req_t     a_req,
    input  wire logic                  a_out_reg_en,
    output logic [`EBR_WORD_W-1:0]     a_rdata,
    input  wire ebr_pkg::ebr_shape_t   b_shape,
    input  wire ebr_pkg::ebr_req_t     b_req,
    input  wire logic                  b_out_reg_en,
    output logic [`EBR_WORD_W-1:0]     b_rdata
);
    import ebr_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                        rst_meta;     // Reset release, stage one
    logic                        rst_sync_n;   // Reset release, stage two
    logic                        out_clr;      // Any output clear source
    logic [`EBR_WORD_W-1:0]      mem [0:`EBR_WORDS-1]; // The array
    ebr_req_t                    req_q   [2];  // Input registers
    ebr_shape_t                  shape_q [2];  // Registered shapes
    logic                        oreg_q  [2];  // Registered output mode
    logic [`EBR_WORD_AW-1:0]     word    [2];  // Physical word addressed
    logic [`EBR_WORD_W-1:0]      wbits   [2];  // Bits written this cycle
    logic [`EBR_WORD_W-1:0]      wval    [2];  // Values of those bits
    logic [`EBR_WORD_W-1:0]      merged  [2];  // Word as this port sees it
    logic [`EBR_WORD_W-1:0]      next_rd [2];  // Read data in port shape
    logic [`EBR_WORD_W-1:0]      ram_q   [2];  // Read latch, flow-through
    logic [`EBR_WORD_W-1:0]      out_q   [2];  // Pipelined output register

    // ------------------------------------------------------------
    // Shape mapping
    // ------------------------------------------------------------
    // Places port data bit j of a shape into the 36-bit physical word
    function automatic ebr_map_t ebr_map(ebr_shape_t s,
                                         logic [`EBR_ADDR_W-1:0] addr,
                                         int j);
        ebr_map_t m;
        int       w;
        int       d;
        m = '0;
        w = 1 << int'(s);
        d = ((int'(addr) * w) % 32) + j;
        case (s)
            EBR_S1, EBR_S2, EBR_S4, EBR_S8: begin
                m.ok  = (j < w);
                m.pos = 6'(((d / 8) * 9) + (d % 8));
            end
            EBR_S9: begin
                m.ok  = (j < 9);
                m.pos = 6'((int'(addr[1:0]) * 9) + j);
            end
            EBR_S16: begin
                m.ok   = (j < 16);
                m.pos  = 6'((((int'(addr[0]) * 2) + (j / 8)) * 9) + (j % 8));
                m.lane = 2'(j / 8);
            end
            EBR_S18: begin
                m.ok   = (j < 18);
                m.pos  = 6'((int'(addr[0]) * 18) + j);
                m.lane = 2'(j / 9);
            end
            EBR_S32: begin
                m.ok   = (j < 32);
                m.pos  = 6'(((j / 8) * 9) + (j % 8));
                m.lane = 2'(j / 8);
            end
            default: begin  // 128 x 36 maps straight through
                m.ok   = 1'b1;
                m.pos  = 6'(j);
                m.lane = 2'(j / 9);
            end
        endcase
        return m;
    endfunction : ebr_map

    // Physical word index for a shape and address
    function automatic logic [`EBR_WORD_AW-1:0] ebr_word(
        ebr_shape_t s, logic [`EBR_ADDR_W-1:0] addr);
        case (s)
            EBR_S1, EBR_S2, EBR_S4, EBR_S8:
                ebr_word = 7'((int'(addr) << int'(s)) >> 5);
            EBR_S9:           ebr_word = addr[8:2];
            EBR_S16, EBR_S18: ebr_word = addr[7:1];
            default:          ebr_word = addr[6:0];
        endcase
    endfunction : ebr_word

    // ------------------------------------------------------------
    // Reset release and output clear
    // ------------------------------------------------------------
    // Two-stage release of the power-up reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Power-up, output clear and chip clear, nothing else
    assign out_clr = out_aclr | ~chip_wide_clear_n | ~rst_sync_n;

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    // No clear at all: they only move on enabled edges
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            req_q[0]   <= a_req;
            req_q[1]   <= b_req;
            shape_q[0] <= a_shape;
            shape_q[1] <= b_shape;
            oreg_q[0]  <= a_out_reg_en;
            oreg_q[1]  <= b_out_reg_en;
        end
    end

    // ------------------------------------------------------------
    // Per-port datapath and output registers
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        // Write mask, aligned data and shaped read data
        always_comb begin
            ebr_map_t m;
            m          = '0;
            word[p]    = ebr_word(shape_q[p], req_q[p].addr);
            wbits[p]   = '0;
            wval[p]    = '0;
            for (int j = 0; j < `EBR_WORD_W; j++) begin
                m = ebr_map(shape_q[p], req_q[p].addr, j);
                // Mask high drops a lane; all low leaves only we
                if (m.ok && req_q[p].we && !req_q[p].bmask[m.lane]) begin
                    wbits[p][m.pos] = 1'b1;
                    wval[p][m.pos]  = req_q[p].wdata[j];
                end
            end
            // Own write shows through; the other port's does not
            merged[p]  = (mem[word[p]] & ~wbits[p]) | wval[p];
            next_rd[p] = '0;
            for (int j = 0; j < `EBR_WORD_W; j++) begin
                m = ebr_map(shape_q[p], req_q[p].addr, j);
                next_rd[p][j] = m.ok & merged[p][m.pos];
            end
        end

        // Read latch, updated on every enabled edge
        always_ff @(posedge sys_clk) begin
            if (clk_en) begin
                ram_q[p] <= next_rd[p];
            end
        end

        // Pipelined output register, cleared at once by any clear
        always_ff @(posedge sys_clk or posedge out_clr) begin
            if (out_clr) begin
                out_q[p] <= '0;
            end else if (clk_en) begin
                out_q[p] <= ram_q[p];
            end
        end
    end

    // ------------------------------------------------------------
    // Array write, both ports on one edge
    // ------------------------------------------------------------
    // Single-edge path kept short for the 250 MHz target
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < `EBR_WORD_W; i++) begin
                    if (wbits[p][i]) begin
                        mem[word[p]][i] <= wval[p][i];
                    end
                end
            end
        end
    end

    // Flow-through or registered read data
    assign a_rdata = oreg_q[0] ? out_q[0] : ram_q[0];
    assign b_rdata = oreg_q[1] ? out_q[1] : ram_q[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    AST_FREEZE: assert property (
        !clk_en |=> $stable(ram_q[0]) && $stable(ram_q[1]) &&
                    (out_clr || $stable(out_q[0]) && $stable(out_q[1])))
        else $error("block moved while clock enable was low");

    AST_CLR_NOW: assert property (
        disable iff (1'b0) out_aclr |-> out_q[0] == '0 && out_q[1] == '0)
        else $error("output clear did not act at once");

    AST_PWRUP: assert property (
        disable iff (1'b0) !rst_sync_n |-> out_q[0] == '0)
        else $error("output register not clear during reset");

    AST_SAME_NEW: assert property (
        clk_en && req_q[0].we && req_q[0].bmask == '0 &&
        shape_q[0] == EBR_S36 |=> ram_q[0] == $past(req_q[0].wdata))
        else $error("same-port read did not return new data");

    AST_MIXED_OLD: assert property (
        clk_en && !req_q[1].we && req_q[0].we && word[0] == word[1] &&
        shape_q[1] == EBR_S36 |=> ram_q[1] == $past(mem[word[1]]))
        else $error("other-port read did not return old data");

    AST_MASK_KEEP: assert property (
        clk_en && req_q[0].we && req_q[0].bmask[0] &&
        shape_q[0] == EBR_S36 && !(req_q[1].we && word[1] == word[0])
        |=> ram_q[0][8:0] == $past(mem[word[0]][8:0]))
        else $error("masked lane was overwritten");

    AST_NOMASK: assert property (
        req_q[0].we && req_q[0].bmask == '0 && shape_q[0] == EBR_S36
        |-> wbits[0] == '1)
        else $error("unmasked write did not cover the word");

    AST_TWO_WRITES: assert property (
        clk_en && req_q[0].we && req_q[1].we && word[0] != word[1] &&
        shape_q[0] == EBR_S36 && shape_q[1] == EBR_S36 &&
        req_q[0].bmask == '0 && req_q[1].bmask == '0
        |=> mem[$past(word[0])] == $past(req_q[0].wdata) &&
            mem[$past(word[1])] == $past(req_q[1].wdata))
        else $error("simultaneous writes were not both stored");

    AST_PIPE: assert property (
        clk_en && !out_clr ##1 !out_clr |-> out_q[1] == $past(ram_q[1]))
        else $error("output register did not follow the read latch");

endmodule : ebr_ram

//--- shared/ebr_consts.svh
// Constants for the embedded block RAM: capacity, widths and clock
`ifndef EBR_CONSTS_SVH
`define EBR_CONSTS_SVH

// ------------------------------------------------------------
// Capacity
// ------------------------------------------------------------
`define EBR_DATA_BITS   4096   // Data bits in the array
`define EBR_TOTAL_BITS  4608   // Data bits plus one parity bit per lane
`define EBR_WORDS       128    // Physical words of the array
`define EBR_WORD_W      36     // Physical word width, four 9-bit lanes
`define EBR_WORD_AW     7      // Physical word index width
`define EBR_LANES       4      // Byte lanes per physical word
`define EBR_LANE_W      9      // Eight data bits and one parity bit
`define EBR_ADDR_W      12     // Widest port address, the 4K x 1 shape

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define EBR_CLK_MHZ     250    // Highest intended clock rate
`define EBR_CLK_NS      4      // Period at that rate

`endif

//--- shared/ebr_pkg.sv
// Types shared by the embedded block RAM and its users
`include "ebr_consts.svh"

package ebr_pkg;

    // Port shapes, depth by width; first four hold data bits only
    typedef enum logic [3:0] {
        EBR_S1,   // 4K x 1
        EBR_S2,   // 2K x 2
        EBR_S4,   // 1K x 4
        EBR_S8,   // 512 x 8
        EBR_S9,   // 512 x 9
        EBR_S16,  // 256 x 16
        EBR_S18,  // 256 x 18
        EBR_S32,  // 128 x 32
        EBR_S36   // 128 x 36
    } ebr_shape_t;

    // One port request, captured by the input registers
    typedef struct packed {
        logic                      we;     // Write this cycle
        logic [`EBR_LANES-1:0]     bmask;  // High bit suppresses a lane
        logic [`EBR_ADDR_W-1:0]    addr;   // Word address in port shape
        logic [`EBR_WORD_W-1:0]    wdata;  // Write data, low bits used
    } ebr_req_t;

    // Where one port data bit lands in the physical word
    typedef struct packed {
        logic       ok;    // Bit exists in this shape
        logic [5:0] pos;   // Physical bit position
        logic [1:0] lane;  // Byte enable that governs it
    } ebr_map_t;

endpackage : ebr_pkg

//--- sim/ebr_user.sv
// Fabric-side user logic: makes and checks lane parity for the block RAM
module ebr_user (
    input  wire logic [31:0] data,     // Plain data from the user
    output logic      [35:0] word,     // Same data with a parity bit per lane
    input  wire logic [35:0] rd_word,  // Word read back from the RAM
    output logic             perr      // Some lane fails its parity check
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Parity made in the fabric, the RAM only stores the ninth bit
    // ------------------------------------------------------------
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            word[9*l +: 9] = {^data[8*l +: 8], data[8*l +: 8]};
        end
    end

    // Even parity over each 9-bit lane must come out zero
    always_comb begin
        perr = 1'b0;
        for (int l = 0; l < 4; l++) begin
            perr = perr | (^rd_word[9*l +: 9]);
        end
    end
endmodule : ebr_user

//--- sim/tb.sv
// Self-checking bench for the embedded block RAM
`include "ebr_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebr_pkg::*;

    logic        sys_clk, rstn, clk_en, out_aclr, chip_wide_clear_n;
    ebr_shape_t  a_shape, b_shape;      // Port shapes
    ebr_req_t    a_req, b_req;          // Port requests
    logic        a_out_reg_en, b_out_reg_en;
    logic [35:0] a_rdata, b_rdata;
    logic [35:0] shadow [128];          // Expected array contents
    // Shapes that carry data bits only, besides the full word
    ebr_shape_t  sl [6] = '{EBR_S1, EBR_S2, EBR_S4, EBR_S8, EBR_S16, EBR_S32};
    logic [31:0] usr_data;
    logic [35:0] usr_word;
    logic        usr_perr;
    int          n_fail, check_count, cycles;

    ebr_ram ebr_ram_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .out_aclr(out_aclr), .chip_wide_clear_n(chip_wide_clear_n),
        .a_shape(a_shape), .a_req(a_req), .a_out_reg_en(a_out_reg_en),
        .a_rdata(a_rdata), .b_shape(b_shape), .b_req(b_req),
        .b_out_reg_en(b_out_reg_en), .b_rdata(b_rdata));
    ebr_user ebr_user_inst (.data(usr_data), .word(usr_word),
        .rd_word(b_rdata), .perr(usr_perr));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(string name, logic [35:0] seen, logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic ebr_req_t mk(logic we, logic [3:0] m, int ad,
                                    logic [35:0] wd);
        ebr_req_t r;
        r.we    = we;
        r.bmask = m;
        r.addr  = 12'(ad);
        r.wdata = wd;
        return r;
    endfunction : mk

    // Lanes whose mask bit is low take the new value
    function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] nw,
                                          logic [3:0] m);
        for (int l = 0; l < 4; l++) begin
            if (!m[l]) old[9*l +: 9] = nw[9*l +: 9];
        end
        return old;
    endfunction : merge

    function automatic logic [35:0] rnd();
        return 36'({$urandom(), $urandom()});
    endfunction : rnd

    // Data bits per word of a data-only shape
    function automatic int shape_w(ebr_shape_t s);
        case (s)
            EBR_S1:  return 1;
            EBR_S2:  return 2;
            EBR_S4:  return 4;
            EBR_S8:  return 8;
            EBR_S16: return 16;
            default: return 32;
        endcase
    endfunction : shape_w

    // Data bits numbered low first over the array, eight per 9-bit lane
    function automatic logic [35:0] exp_rd(ebr_shape_t s, int ad);
        logic [35:0] r;
        int          w;
        int          n;
        r = '0;
        w = shape_w(s);
        for (int j = 0; j < w; j++) begin
            n = ad * w + j;
            r[j] = shadow[n / 32][9 * ((n % 32) / 8) + n % 8];
        end
        return r;
    endfunction : exp_rd

    // One request per port, then reads; flow-through data settled at return
    task automatic run(ebr_shape_t sa, ebr_req_t ra, ebr_shape_t sb,
                       ebr_req_t rb);
        @(posedge sys_clk);
        a_shape <= sa;
        a_req   <= ra;
        b_shape <= sb;
        b_req   <= rb;
        @(posedge sys_clk);
        a_req.we <= 1'b0;
        b_req.we <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : run

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [35:0] d, e, hold;
        logic [3:0]  m;
        int          a, b, wp, rp;
        ebr_shape_t  sb;
        rstn = 1'b0;
        clk_en = 1'b1;
        out_aclr = 1'b0;
        chip_wide_clear_n = 1'b1;
        a_shape = EBR_S36;
        b_shape = EBR_S36;
        a_req = '0;
        b_req = '0;
        a_out_reg_en = 1'b0;
        b_out_reg_en = 1'b0;
        usr_data = '0;
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        void'($urandom(50780));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Both ports write at once, no mask applied
        for (int i = 0; i < 64; i++) begin
            d = rnd();
            e = rnd();
            run(EBR_S36, mk(1, 0, 2*i, d), EBR_S36, mk(1, 0, 2*i+1, e));
            check("a_fill", a_rdata, d);
            check("b_fill", b_rdata, e);
            shadow[2*i] = d;
            shadow[2*i+1] = e;
        end
        // Masked writes on A, reads on B, sometimes the same word
        for (int i = 0; i < 60; i++) begin
            a = $urandom_range(127);
            b = (i % 4 == 0) ? a : $urandom_range(127);
            d = rnd();
            m = 4'($urandom());
            e = merge(shadow[a], d, m);
            run(EBR_S36, mk(1, m, a, d), EBR_S36, mk(0, 0, b, '0));
            check("a_masked", a_rdata, e);
            check("b_other", b_rdata, shadow[b]);
            shadow[a] = e;
        end
        // Narrow shapes, and a suppressed single-lane write
        for (int i = 0; i < 16; i++) begin
            a = $urandom_range(511);
            b = $urandom_range(255);
            run(EBR_S9, mk(1, 4'h1, a, rnd()), EBR_S18, mk(0, 0, b, '0));
            check("a_s9", a_rdata, 36'(shadow[a/4][9*(a%4) +: 9]));
            check("b_s18", b_rdata, 36'(shadow[b/2][18*(b%2) +: 18]));
        end
        // Data-only shapes read on B
        for (int i = 0; i < 16; i++) begin
            sb = sl[i % 6];
            b = $urandom_range(`EBR_DATA_BITS / shape_w(sb) - 1);
            run(EBR_S36, mk(0, 0, 0, '0), sb, mk(0, 0, b, '0));
            check("b_shape", b_rdata, exp_rd(sb, b));
        end
        // FIFO on the block: both pointers live here in the fabric
        wp = 0;
        rp = 0;
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                d = rnd();
                run(EBR_S36, mk(1, 0, 96 + wp, d), EBR_S36, mk(0, 0, 0, '0));
                shadow[96 + wp] = d;
                wp++;
            end else begin
                run(EBR_S36, mk(0, 0, 0, '0), EBR_S36, mk(0, 0, 96 + rp, '0));
                check("b_fifo", b_rdata, shadow[96 + rp]);
                rp++;
            end
        end
        // Clock enable low: writes ignored, A output frozen
        @(posedge sys_clk);
        clk_en <= 1'b0;
        a_shape <= EBR_S36;
        b_shape <= EBR_S36;
        a_req  <= mk(1, 0, 5, ~shadow[5]);
        b_req  <= mk(1, 0, 5, ~shadow[5]);
        #1 hold = a_rdata;
        repeat (3) @(posedge sys_clk);
        #1 check("a_frozen", a_rdata, hold);
        @(posedge sys_clk);
        a_req <= mk(0, 0, 5, '0);
        b_req <= mk(0, 0, 5, '0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check("a_unwritten", a_rdata, shadow[5]);
        // Output register on A, clears act without a clock edge
        @(posedge sys_clk);
        a_out_reg_en <= 1'b1;
        run(EBR_S36, mk(0, 0, 7, '0), EBR_S36, mk(0, 0, 7, '0));
        @(posedge sys_clk);
        #1 check("a_piped", a_rdata, shadow[7]);
        @(posedge sys_clk);
        out_aclr <= 1'b1;
        #1 check("a_aclr", a_rdata, '0);
        check("b_flow", b_rdata, shadow[7]);
        @(posedge sys_clk);
        out_aclr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check("a_reload", a_rdata, shadow[7]);
        @(posedge sys_clk);
        chip_wide_clear_n <= 1'b0;
        #1 check("a_chipclr", a_rdata, '0);
        @(posedge sys_clk);
        chip_wide_clear_n <= 1'b1;
        // Mid-run reset: output register held clear, then reloads
        @(posedge sys_clk);
        rstn <= 1'b0;
        #1 check("a_rst", a_rdata, '0);
        @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("a_rst_out", a_rdata, shadow[7]);
        // Parity lanes made by the user logic survive a round trip
        @(posedge sys_clk);
        usr_data <= $urandom();
        #1;
        run(EBR_S36, mk(1, 0, 9, usr_word), EBR_S36, mk(0, 0, 9, '0));
        run(EBR_S36, mk(0, 0, 9, '0), EBR_S36, mk(0, 0, 9, '0));
        check("b_parity_word", b_rdata, usr_word);
        check("b_parity_err", 36'(usr_perr), '0);
        tally_and_finish();
    end
endmodule : tb
